//--- bench/bsc_far_model.sv
`include "bsc_consts.svh"

// Stand-in for the conversion source and the commutation pulse source
module bsc_far_model (
   input  wire logic                  clk,          // System clock
   input  wire logic                  sys_rst,      // Synchronous reset
   input  wire logic                  conv_req,     // Conversion wanted
   input  wire logic [`BSC_POT_W-1:0] conv_data,    // Value to convert
   input  wire logic                  step_req,     // 30-degree pulse wanted
   input  wire logic                  step_forced,  // Pulse goes on the forced line
   output logic                       pot_valid,    // Conversion ready
   output logic      [`BSC_POT_W-1:0] pot_value,    // Conversion result
   output logic                       zero_cross,   // Crossing pulse
   output logic                       forced_step   // Forced step pulse
);
   logic                  next_pot_valid;
   logic [`BSC_POT_W-1:0] next_pot_value;
   // Result flips every idle cycle so a stale sample can never pass as fresh
   always_comb begin
      next_pot_valid = conv_req && !sys_rst;
      next_pot_value = conv_req ? conv_data : ~pot_value;
   end
   // Everything leaves one edge after the request, like a sampled source
   always_ff @(posedge clk) begin
      pot_valid   <= next_pot_valid;
      pot_value   <= next_pot_value;
      zero_cross  <= step_req && !step_forced && !sys_rst;
      forced_step <= step_req && step_forced && !sys_rst;
   end
endmodule

//--- bench/bsc_loop_checker.sv
`include "bsc_consts.svh"

// Run timing and duty arithmetic seen at the loop's ports
module bsc_loop_checker (
   input wire logic                  clk,         // System clock
   input wire logic                  sys_rst,     // Synchronous reset
   input wire bsc_pkg::bsc_cfg_t     cfg,         // Mode and range
   input wire bsc_pkg::bsc_start_t   start,       // Start-up status
   input wire logic                  pot_valid,   // Run trigger
   input wire logic [`BSC_POT_W-1:0] pot_value,   // Conversion
   input wire logic [11:0]           duty,        // Duty output
   input wire logic                  duty_valid,  // Duty update pulse
   input wire logic [15:0]           speed_rpm,   // Measured speed
   input wire logic                  bemf_enable  // Crossings in use
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [11:0] dmax;   // Duty ceiling
   logic [21:0] oprod;  // Conversion times ceiling
   logic [25:0] dprod;  // Conversion times full-scale speed
   logic [11:0] fduty;  // Start-up duty after the ceiling
   // Expected values formed once, so each property stays a plain comparison
   assign dmax  = cfg.fast_core ? `BSC_DUTY_MAX_FAST : `BSC_DUTY_MAX_SLOW;
   assign oprod = 22'(pot_value) * 22'(dmax);
   assign dprod = 26'(pot_value) * 26'(`BSC_SPEED_MAX);
   assign fduty = (start.duty < dmax) ? start.duty : dmax;

   // A run outside forced commutation, then the mode it runs in
   sequence s_run;
      pot_valid && !start.forced;
   endsequence
   sequence s_open;
      s_run ##0 (cfg.mode == bsc_pkg::BSC_OPEN);
   endsequence
   sequence s_up;
      s_run ##0 (cfg.mode == bsc_pkg::BSC_CLASSIC && dprod[25:10] > speed_rpm && duty < dmax);
   endsequence
   sequence s_down;
      s_run ##0 (cfg.mode == bsc_pkg::BSC_CLASSIC && dprod[25:10] < speed_rpm && duty > 0);
   endsequence

   run_answer_a : assert property (pot_valid |=> duty_valid)
      else $error("no duty update after a run");
   no_spurious_a : assert property (!pot_valid |=> !duty_valid)
      else $error("duty update without a run");
   open_duty_a : assert property (s_open |=> duty == $past(oprod[21:10]))
      else $error("open loop duty not scaled conversion");
   classic_up_a : assert property (s_up |=> duty == $past(duty) + 12'h001)
      else $error("classic step up wrong");
   classic_down_a : assert property (s_down |=> duty == $past(duty) - 12'h001)
      else $error("classic step down wrong");
   duty_ceiling_a : assert property (duty_valid |-> duty <= $past(dmax))
      else $error("duty above ceiling");
   forced_duty_a : assert property (pot_valid && start.forced && cfg.mode != 2'h3 |=> duty == $past(fduty))
      else $error("forced duty wrong");
   mode_hold_a : assert property (s_run ##0 cfg.mode == 2'h3 |=> $stable(duty))
      else $error("unused mode changed duty");
   bemf_follow_a : assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> bemf_enable == !$past(start.forced))
      else $error("crossing enable not inverse of forced");
endmodule

bind bsc_speed_loop bsc_loop_checker chk (
   .clk(clk), .sys_rst(sys_rst), .cfg(cfg), .start(start), .pot_valid(pot_valid),
   .pot_value(pot_value), .duty(duty), .duty_valid(duty_valid), .speed_rpm(speed_rpm),
   .bemf_enable(bemf_enable)
);

//--- bench/tb_top.sv
`include "bsc_consts.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic                  clk;          // System clock
   logic                  sys_rst;      // Synchronous reset
   bsc_pkg::bsc_cfg_t     cfg;          // Loop configuration
   bsc_pkg::bsc_start_t   start;        // Start-up status
   logic                  conv_req;     // Conversion request to the model
   logic [`BSC_POT_W-1:0] conv_data;    // Conversion value
   logic                  step_req;     // Pulse request to the model
   logic                  step_forced;  // Pulse line select
   logic                  pot_valid;    // Model conversion strobe
   logic [`BSC_POT_W-1:0] pot_value;    // Model conversion value
   logic                  zero_cross;   // Model crossing pulse
   logic                  forced_step;  // Model forced pulse
   logic [11:0]           duty;         // Loop duty
   logic                  duty_valid;   // Loop duty strobe
   logic [15:0]           speed_rpm;    // Loop speed
   logic                  bemf_enable;  // Loop crossing enable
   int                    n_mismatch;   // Mismatches seen
   int                    cmp_count;    // Comparisons made

   bsc_far_model far (.clk(clk), .sys_rst(sys_rst), .conv_req(conv_req), .conv_data(conv_data),
      .step_req(step_req), .step_forced(step_forced), .pot_valid(pot_valid),
      .pot_value(pot_value), .zero_cross(zero_cross), .forced_step(forced_step));
   bsc_speed_loop uut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .start(start),
      .pot_valid(pot_valid), .pot_value(pot_value), .zero_cross(zero_cross),
      .forced_step(forced_step), .duty(duty), .duty_valid(duty_valid),
      .speed_rpm(speed_rpm), .bemf_enable(bemf_enable));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk_duty(input logic [11:0] exp);
      cmp_count++;
      if (duty !== exp || duty_valid !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH %0t duty %0d expected %0d", $time, duty, exp);
      end
   endtask
   task automatic chk_speed(input int lo, input int hi);
      cmp_count++;
      if ((speed_rpm >= lo && speed_rpm <= hi) !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH %0t speed %0d outside %0d..%0d", $time, speed_rpm, lo, hi);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Every helper starts and ends just after a rising edge
   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
   endtask
   task automatic set_cfg(input bsc_pkg::bsc_mode_t m, input logic fc);
      cfg = '{mode: m, fast_core: fc, pole_pairs: 4'h4};
   endtask
   // n back-to-back runs; returns with the last duty strobe showing
   task automatic run(input logic [9:0] pot, input int n);
      conv_req  = 1'b1;
      conv_data = pot;
      repeat (n) @(posedge clk);
      #1 conv_req = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic frc, input int gap);
      step_forced = frc;
      step_req    = 1'b1;
      @(posedge clk);
      #1 step_req = 1'b0;
      repeat (gap - 1) @(posedge clk);
      #1;
   endtask
   function automatic logic [11:0] pi_exp(input int err, input int integ);
      int v;
      v = (err * int'(`BSC_KP) + integ * int'(`BSC_KI)) >>> `BSC_PI_SHIFT;
      return (v > 2000) ? 12'h7d0 : 12'(v);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_open();
      logic [9:0] pots [3] = '{10'h000, 10'h200, 10'h3ff};
      for (int fc = 0; fc < 2; fc++) begin
         set_cfg(bsc_pkg::BSC_OPEN, fc[0]);
         foreach (pots[i]) begin
            run(pots[i], 1);
            chk_duty(12'((22'(pots[i]) * (fc ? 22'd3500 : 22'd2000)) >> 10));
         end
      end
   endtask
   task automatic t_classic();
      do_reset();
      set_cfg(bsc_pkg::BSC_CLASSIC, 1'b0);
      run(10'h000, 1);
      chk_duty(12'h000);
      run(10'h200, 2);
      chk_duty(12'h002);
      cfg.mode = bsc_pkg::bsc_mode_t'(2'h3);
      run(10'h200, 1);
      chk_duty(12'h002);
      cfg.mode = bsc_pkg::BSC_CLASSIC;
      pulse(1'b0, 6400);
      pulse(1'b0, 40);
      chk_speed(`BSC_RPM_NUM / (101 * 4), `BSC_RPM_NUM / (99 * 4));
      run(10'h200, 1);
      chk_duty(12'h001);
   endtask
   task automatic t_pi();
      do_reset();
      set_cfg(bsc_pkg::BSC_PI, 1'b0);
      start = '{forced: 1'b1, sustain: 1'b1, duty: 12'h1f4};
      repeat (2) @(posedge clk);
      #1 chk_flag(bemf_enable, 1'b0);
      pulse(1'b0, 200);
      pulse(1'b0, 40);
      chk_flag(speed_rpm === 16'h0000, 1'b1);
      run(10'h100, 1);
      chk_duty(12'h1f4);
      start = '{forced: 1'b0, sustain: 1'b0, duty: 12'h1f4};
      run(10'h100, 1);
      chk_duty(pi_exp(1000, 2000));
      chk_flag(bemf_enable, 1'b1);
      run(10'h100, 1);
      chk_duty(pi_exp(1000, 3000));
      run(10'h3ff, 40);
      chk_duty(12'h7d0);
      start = '{forced: 1'b1, sustain: 1'b0, duty: 12'hbb8};
      run(10'h100, 1);
      chk_duty(12'h7d0);
      start.forced = 1'b0;
      run(10'h100, 1);
      chk_duty(pi_exp(1000, 1000));
      // Forced steps must feed the meter so the regulator trains on real speed
      start = '{forced: 1'b1, sustain: 1'b1, duty: 12'h1f4};
      pulse(1'b1, 6400);
      pulse(1'b1, 40);
      chk_speed(`BSC_RPM_NUM / (101 * 4), `BSC_RPM_NUM / (99 * 4));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Runs take about 13200 cycles; the watchdog allows far more
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end
   initial begin
      n_mismatch  = 0;
      cmp_count   = 0;
      conv_req    = 1'b0;
      conv_data   = 10'h000;
      step_req    = 1'b0;
      step_forced = 1'b0;
      start       = '{forced: 1'b0, sustain: 1'b0, duty: 12'h000};
      set_cfg(bsc_pkg::BSC_OPEN, 1'b0);
      do_reset();
      chk_flag(duty === 12'h000 && speed_rpm === 16'h0000 && !duty_valid, 1'b1);
      t_open();
      t_classic();
      t_pi();
      stop_test();
   end
endmodule

//--- hw/bsc_consts.svh
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

// Clock period in nanoseconds (250 MHz system clock)
`define BSC_CLK_NS           4
// Period of one tick of the speed interval timer, in nanoseconds
`define BSC_TICK_NS          256
// Clock cycles per timer tick, derived from the two times above
`define BSC_TICK_CYC         (`BSC_TICK_NS / `BSC_CLK_NS)
// Timer ticks per second
`define BSC_TICK_HZ          (1000000000 / `BSC_TICK_NS)
// 30 electrical degrees per interval, so twelve intervals per electrical turn
`define BSC_SEG_PER_TURN     12
// rpm = RPM_NUM / (ticks * pole_pairs), with RPM_NUM = 60 * tick_hz / 12
`define BSC_RPM_NUM          (60 * `BSC_TICK_HZ / `BSC_SEG_PER_TURN)
`define BSC_RPM_NUM_W        25
// Duty range for a 20 kHz PWM: slow core clock and fast core clock
`define BSC_DUTY_MAX_SLOW    12'h7d0
`define BSC_DUTY_MAX_FAST    12'hdac
// Conversion result width
`define BSC_POT_W            10
// Demand speed at full scale of the potentiometer, in rpm
`define BSC_SPEED_MAX        16'h0fa0
// Regulator gains and output scaling shift
`define BSC_KP               16'h0040
`define BSC_KI               16'h0004
`define BSC_PI_SHIFT         8
// Integral limit, keeps the accumulator from winding up
`define BSC_INTEG_LIM        32'h00ff_ffff

`endif

//--- hw/bsc_pkg.sv
package bsc_pkg;

   // Speed control mode selected by the user
   typedef enum logic [1:0] {
      BSC_OPEN,
      BSC_CLASSIC,
      BSC_PI
   } bsc_mode_t;

   // Static configuration of the loop
   typedef struct packed {
      bsc_mode_t   mode;        // Control mode
      logic        fast_core;   // 1: 3500-step duty range, 0: 2000-step range
      logic [3:0]  pole_pairs;  // Motor pole-pair count
   } bsc_cfg_t;

   // Start-up sequencer status, driven by the neighbouring start-up logic
   typedef struct packed {
      logic        forced;      // Ramp or sustaining time in progress
      logic        sustain;     // Sustaining time in progress
      logic [11:0] duty;        // Duty used for forced commutation
   } bsc_start_t;

   // Speed meter divider state
   typedef enum logic [1:0] {
      BSC_M_IDLE,
      BSC_M_DIV,
      BSC_M_DONE
   } bsc_meter_st_t;

endpackage

//--- hw/bsc_speed_loop.sv
// How it works
// - Three modes: open, classic closed, PI
// - Open loop duty follows 10-bit conversion
// - Scale conversion to 2000 or 3500 duty
// - Classic mode steps duty by one unit
// - Demand speed scaled from potentiometer reading
// - PI error and integral accumulate each run
// - Output is Kp*error plus Ki*integral, scaled
// - Speed from timer ticks per 30 degrees
// - Mechanical turn equals pole-pair electrical turns
// - Zero crossings ignored during forced commutation
// - PI trains during sustain, applied after
`include "bsc_consts.svh"

module bsc_speed_loop (
   input  wire logic                     clk,          // System clock, 250 MHz
   input  wire logic                     sys_rst,      // Synchronous reset, active high
   input  wire bsc_pkg::bsc_cfg_t        cfg,          // Mode, duty range, pole pairs
   input  wire bsc_pkg::bsc_start_t      start,        // Start-up sequencer status
   input  wire logic                     pot_valid,    // Pulse, new conversion result
   input  wire logic [`BSC_POT_W-1:0]    pot_value,    // Potentiometer conversion
   input  wire logic                     zero_cross,   // Pulse, filtered zero crossing
   input  wire logic                     forced_step,  // Pulse, forced 30-degree step
   output logic      [11:0]              duty,         // Duty to PWM generator
   output logic                          duty_valid,   // Pulse, duty updated
   output logic      [15:0]              speed_rpm,    // Measured speed, rpm
   output logic                          bemf_enable   // High while crossings are used
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [15:0]  meter_rpm;
   logic         meter_valid;
   logic         seg_event;
   logic [11:0]  duty_max;
   logic [11:0]  duty_open;
   logic [15:0]  demand;
   logic [21:0]  open_prod;
   logic [25:0]  dem_prod;

   logic [11:0]  next_duty;
   logic         next_duty_valid;
   logic [15:0]  next_speed;
   logic         next_bemf;
   logic [31:0]  integ, next_integ;

   logic signed [16:0] err;
   logic signed [33:0] integ_sum;
   logic signed [31:0] integ_sat;
   logic signed [33:0] p_term;
   logic signed [48:0] i_term;
   logic signed [49:0] pi_sum;
   logic signed [49:0] pi_scaled;
   logic        [11:0] pi_sat;

   ////////////////////////////////////////////////////////////////////////////
   // Speed measurement

   // Forced steps stand in for crossings while the rotor is pushed, so the
   // meter keeps real interval figures for the regulator to train on
   assign seg_event = cfg.mode == bsc_pkg::BSC_OPEN ? 1'b0 :
                      start.forced ? forced_step : zero_cross;

   bsc_speed_meter u_meter (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .seg_event   (seg_event),
      .pole_pairs  (cfg.pole_pairs),
      .speed_rpm   (meter_rpm),
      .speed_valid (meter_valid)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Scaling of the conversion result

   // Duty range depends on the core clock the PWM counts on
   assign duty_max  = cfg.fast_core ? `BSC_DUTY_MAX_FAST : `BSC_DUTY_MAX_SLOW;
   // Divide by 1024 with a shift; full scale lands 2 below max on the 2000 range, 4 below on the 3500 range
   assign open_prod = pot_value * duty_max;
   assign duty_open = open_prod[21:10];
   assign dem_prod  = pot_value * `BSC_SPEED_MAX;
   assign demand    = dem_prod[25:10];

   ////////////////////////////////////////////////////////////////////////////
   // PI arithmetic

   // Error is demand minus measurement, both unsigned 16-bit
   assign err       = $signed({1'b0, demand}) - $signed({1'b0, speed_rpm});
   assign integ_sum = 34'(signed'(integ)) + 34'(err);

   // Clamp the integral so a long stall cannot wind it up without limit
   always_comb begin
      if (integ_sum > 34'(signed'(`BSC_INTEG_LIM))) begin
         integ_sat = signed'(`BSC_INTEG_LIM);
      end else if (integ_sum < -34'(signed'(`BSC_INTEG_LIM))) begin
         integ_sat = -signed'(`BSC_INTEG_LIM);
      end else begin
         integ_sat = integ_sum[31:0];
      end
   end

   assign p_term    = err * $signed({1'b0, `BSC_KP});
   assign i_term    = integ_sat * $signed({1'b0, `BSC_KI});
   assign pi_sum    = 50'(p_term) + 50'(i_term);
   assign pi_scaled = pi_sum >>> `BSC_PI_SHIFT;

   // Regulator output limited to the usable duty range
   always_comb begin
      if (pi_scaled < 50'sd0) begin
         pi_sat = 12'h000;
      end else if (pi_scaled > 50'(duty_max)) begin
         pi_sat = duty_max;
      end else begin
         pi_sat = pi_scaled[11:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control run, next values

   // One run per conversion result; the speed reading simply follows the meter
   always_comb begin
      next_duty       = duty;
      next_duty_valid = 1'b0;
      next_integ      = integ;
      next_speed      = meter_valid ? meter_rpm : speed_rpm;
      next_bemf       = ~start.forced;
      if (cfg.mode != bsc_pkg::BSC_PI ||
          (start.forced && !start.sustain)) begin
         // Ramp runs without a trusted speed, so the integral starts clean
         next_integ   = 32'h0000_0000;
      end
      if (pot_valid) begin
         next_duty_valid = 1'b1;
         if (start.forced) begin
            // Forced commutation drives the start-up duty, clamped to range
            next_duty = start.duty > duty_max ? duty_max : start.duty;
            if (cfg.mode == bsc_pkg::BSC_PI && start.sustain) begin
               // Train on real figures but hold the result back
               next_integ   = integ_sat;
            end
         end else begin
            unique case (cfg.mode)
               bsc_pkg::BSC_OPEN: begin
                  next_duty = duty_open;
               end
               bsc_pkg::BSC_CLASSIC: begin
                  // At most one unit per run, except a duty above max with no down step is set to max; never past either end
                  if (demand > speed_rpm && duty < duty_max) begin
                     next_duty = duty + 12'h001;
                  end else if (demand < speed_rpm && duty != 12'h000) begin
                     next_duty = duty - 12'h001;
                  end else if (duty > duty_max) begin
                     next_duty = duty_max;
                  end
               end
               bsc_pkg::BSC_PI: begin
                  next_integ   = integ_sat;
                  next_duty    = pi_sat;
               end
               default: begin
                  // Unused mode code leaves the duty where it was
                  next_duty = duty;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register stage

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         duty        <= 12'h000;
         duty_valid  <= 1'b0;
         speed_rpm   <= 16'h0000;
         bemf_enable <= 1'b0;
         integ       <= 32'h0000_0000;
      end else begin
         duty        <= next_duty;
         duty_valid  <= next_duty_valid;
         speed_rpm   <= next_speed;
         bemf_enable <= next_bemf;
         integ       <= next_integ;
      end
   end

endmodule

//--- hw/bsc_speed_meter.sv
`include "bsc_consts.svh"

// Counts timer ticks over each 30-degree interval and turns the count into rpm
module bsc_speed_meter (
   input  wire logic        clk,         // System clock
   input  wire logic        sys_rst,     // Synchronous reset
   input  wire logic        seg_event,   // Pulse at each 30-degree boundary
   input  wire logic [3:0]  pole_pairs,  // Motor pole-pair count
   output logic      [15:0] speed_rpm,   // Last measured mechanical speed
   output logic             speed_valid  // One-cycle pulse, new speed ready
);

   localparam logic [7:0]  TICK_LAST = 8'(`BSC_TICK_CYC - 1);
   localparam logic [24:0] RPM_NUM   = 25'(`BSC_RPM_NUM);

   logic [7:0]              presc, next_presc;
   logic [15:0]             ticks, next_ticks;
   bsc_pkg::bsc_meter_st_t  st, next_st;
   logic [19:0]             den, next_den;
   logic [25:0]             rem, next_rem;
   logic [24:0]             quo, next_quo;
   logic [4:0]              bitn, next_bitn;
   logic [15:0]             next_speed;
   logic                    next_valid;
   logic [25:0]             shifted;

   ////////////////////////////////////////////////////////////////////////////
   // Tick timer and divider, next values
   always_comb begin
      next_presc = presc + 8'h01;
      next_ticks = ticks;
      next_st    = st;
      next_den   = den;
      next_rem   = rem;
      next_quo   = quo;
      next_bitn  = bitn;
      next_speed = speed_rpm;
      next_valid = 1'b0;
      shifted    = {rem[24:0], quo[24]};
      // Ticks saturate so a stalled rotor reads as the slowest speed
      if (presc == TICK_LAST) begin
         next_presc = 8'h00;
         if (ticks != 16'hffff) begin
            next_ticks = ticks + 16'h0001;
         end
      end
      unique case (st)
         bsc_pkg::BSC_M_IDLE: begin
            if (seg_event) begin
               next_ticks = 16'h0000;
               next_presc = 8'h00;
               // Denominator is interval ticks times pole pairs
               next_den   = 20'(ticks * pole_pairs);
               next_rem   = 26'h0000000;
               next_quo   = RPM_NUM;
               next_bitn  = 5'h00;
               next_st    = bsc_pkg::BSC_M_DIV;
            end
         end
         bsc_pkg::BSC_M_DIV: begin
            // One quotient bit per cycle, restoring division
            if (shifted >= {6'h00, den}) begin
               next_rem = shifted - {6'h00, den};
               next_quo = {quo[23:0], 1'b1};
            end else begin
               next_rem = shifted;
               next_quo = {quo[23:0], 1'b0};
            end
            next_bitn = bitn + 5'h01;
            if (bitn == 5'(`BSC_RPM_NUM_W - 1)) begin
               next_st = bsc_pkg::BSC_M_DONE;
            end
         end
         bsc_pkg::BSC_M_DONE: begin
            // Zero denominator or huge quotient saturates the reading
            if (den == 20'h00000 || quo[24:16] != 9'h000) begin
               next_speed = 16'hffff;
            end else begin
               next_speed = quo[15:0];
            end
            next_valid = 1'b1;
            next_st    = bsc_pkg::BSC_M_IDLE;
         end
      endcase
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         presc       <= 8'h00;
         ticks       <= 16'h0000;
         st          <= bsc_pkg::BSC_M_IDLE;
         den         <= 20'h00000;
         rem         <= 26'h0000000;
         quo         <= 25'h0000000;
         bitn        <= 5'h00;
         speed_rpm   <= 16'h0000;
         speed_valid <= 1'b0;
      end else begin
         presc       <= next_presc;
         ticks       <= next_ticks;
         st          <= next_st;
         den         <= next_den;
         rem         <= next_rem;
         quo         <= next_quo;
         bitn        <= next_bitn;
         speed_rpm   <= next_speed;
         speed_valid <= next_valid;
      end
   end

endmodule
